// ### clc_gate_pkg.sv
`default_nettype none

package clc_gate_pkg;

  // Widths of the cell slice
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 3;
  localparam int SRC_SEL_W = 6;
  localparam int SRC_COUNT = 64;
  localparam int NUM_DATA  = 4;

  // Register offsets (word index on the plain port)
  localparam logic [ADDR_W-1:0] ADDR_SEL0 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_SEL1 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_SEL2 = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_SEL3 = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_GLS2 = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_GLS3 = 3'h5;

  // Enable bit positions inside a gate selection register
  localparam int BIT_IN4_TRUE = 7;
  localparam int BIT_IN4_INV  = 6;
  localparam int BIT_IN3_TRUE = 5;
  localparam int BIT_IN3_INV  = 4;
  localparam int BIT_IN2_TRUE = 3;
  localparam int BIT_IN2_INV  = 2;
  localparam int BIT_IN1_TRUE = 1;
  localparam int BIT_IN1_INV  = 0;

  // Source selection field position
  localparam int SEL_FIELD_MSB = 5;
  localparam int SEL_FIELD_LSB = 0;

  // Values after reset
  localparam logic [DATA_W-1:0]    GLS_RESET = 8'h00;
  localparam logic [SRC_SEL_W-1:0] SEL_RESET = 6'h00;
  localparam logic [DATA_W-1:0]    RD_IDLE   = 8'h00;

  // One gate's eight enables, bit 7 first
  typedef struct packed {
    logic in4TrueEn;
    logic in4InvEn;
    logic in3TrueEn;
    logic in3InvEn;
    logic in2TrueEn;
    logic in2InvEn;
    logic in1TrueEn;
    logic in1InvEn;
  } gate_sel_s;

  // Register port request
  typedef struct packed {
    logic              wrStb;
    logic              rdStb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } reg_req_s;

endpackage

`default_nettype wire

// ### clc_gate_select.sv
`timescale 1ns/100ps
`default_nettype none

module clc_gate_select
  import clc_gate_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire reg_req_s             regReq,
  input  wire logic [SRC_COUNT-1:0] sourceBus,
  output logic      [DATA_W-1:0]    rdData,
  output logic      [NUM_DATA-1:0]  cellDataIn,
  output logic                      gate2Out,
  output logic                      gate3Out
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [SRC_SEL_W-1:0] dataSrcSel_reg [NUM_DATA];
  gate_sel_s            gate2Sel_reg;
  gate_sel_s            gate3Sel_reg;
  logic [DATA_W-1:0]    rdData_reg;
  logic [DATA_W-1:0]    rdData_next;
  logic [NUM_DATA-1:0]  cellData_reg;
  logic [NUM_DATA-1:0]  cellData_next;
  logic                 gate2_reg;
  logic                 gate2_next;
  logic                 gate3_reg;
  logic                 gate3_next;

  // OR of the enabled true and inverted terms of one gate
  function automatic logic gate_or(input gate_sel_s s, input logic [NUM_DATA-1:0] d);
    logic acc;
    acc = 1'b0;
    acc = acc | (s.in4TrueEn & d[3]) | (s.in4InvEn & ~d[3]);
    acc = acc | (s.in3TrueEn & d[2]) | (s.in3InvEn & ~d[2]);
    acc = acc | (s.in2TrueEn & d[1]) | (s.in2InvEn & ~d[1]);
    acc = acc | (s.in1TrueEn & d[0]) | (s.in1InvEn & ~d[0]);
    return acc;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Source selection registers, one per data input
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DATA; gi++)
    begin : g_src
      logic [ADDR_W-1:0] myAddr;
      assign myAddr = ADDR_SEL0 + ADDR_W'(gi);

      // Hold the 6-bit source field
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          dataSrcSel_reg[gi] <= SEL_RESET;
        end
        else if (regReq.wrStb && regReq.addr == myAddr)
        begin
          dataSrcSel_reg[gi] <= regReq.wrData[SEL_FIELD_MSB:SEL_FIELD_LSB];
        end
      end

      // Pick the chosen source for this input
      assign cellData_next[gi] = sourceBus[dataSrcSel_reg[gi]];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Gate 2 selection register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gate2Sel_reg <= gate_sel_s'(GLS_RESET);
    end
    else if (regReq.wrStb && regReq.addr == ADDR_GLS2)
    begin
      gate2Sel_reg <= gate_sel_s'(regReq.wrData);
    end
  end

  // Gate 3 selection register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gate3Sel_reg <= gate_sel_s'(GLS_RESET);
    end
    else if (regReq.wrStb && regReq.addr == ADDR_GLS3)
    begin
      gate3Sel_reg <= gate_sel_s'(regReq.wrData);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode, unmapped offsets read zero
  always_comb
  begin
    rdData_next = RD_IDLE;
    if (!regReq.rdStb)
    begin
      rdData_next = RD_IDLE;
    end
    else if (regReq.addr == ADDR_SEL0)
    begin
      rdData_next = {(DATA_W-SRC_SEL_W)'(0), dataSrcSel_reg[0]};
    end
    else if (regReq.addr == ADDR_SEL1)
    begin
      rdData_next = {(DATA_W-SRC_SEL_W)'(0), dataSrcSel_reg[1]};
    end
    else if (regReq.addr == ADDR_SEL2)
    begin
      rdData_next = {(DATA_W-SRC_SEL_W)'(0), dataSrcSel_reg[2]};
    end
    else if (regReq.addr == ADDR_SEL3)
    begin
      rdData_next = {(DATA_W-SRC_SEL_W)'(0), dataSrcSel_reg[3]};
    end
    else if (regReq.addr == ADDR_GLS2)
    begin
      rdData_next = gate2Sel_reg;
    end
    else if (regReq.addr == ADDR_GLS3)
    begin
      rdData_next = gate3Sel_reg;
    end
  end

  // Read data stands for one cycle only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdData_reg <= RD_IDLE;
    end
    else
    begin
      rdData_reg <= rdData_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate evaluation, each gate the OR of its enabled terms
  assign gate2_next = gate_or(gate2Sel_reg, cellData_next);
  assign gate3_next = gate_or(gate3Sel_reg, cellData_next);

  // Register data inputs and gate outputs together
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cellData_reg <= '0;
      gate2_reg    <= 1'b0;
      gate3_reg    <= 1'b0;
    end
    else
    begin
      cellData_reg <= cellData_next;
      gate2_reg    <= gate2_next;
      gate3_reg    <= gate3_next;
    end
  end

  assign rdData     = rdData_reg;
  assign cellDataIn = cellData_reg;
  assign gate2Out   = gate2_reg;
  assign gate3Out   = gate3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_g2_in4;
    @(posedge clk) disable iff (!arst_n)
    ((gate2Sel_reg.in4TrueEn && cellData_next[3]) || (gate2Sel_reg.in4InvEn && !cellData_next[3]))
      |=> gate2Out && cellDataIn[3] == $past(cellData_next[3]);
  endproperty
  a_g2_in4: assert property (p_g2_in4) else $error("gate 2 missed input 4 term");

  property p_g2_in3;
    @(posedge clk) disable iff (!arst_n)
    ((gate2Sel_reg.in3TrueEn && cellData_next[2]) || (gate2Sel_reg.in3InvEn && !cellData_next[2]))
      |=> gate2Out;
  endproperty
  a_g2_in3: assert property (p_g2_in3) else $error("gate 2 missed input 3 term");

  property p_g2_in2;
    @(posedge clk) disable iff (!arst_n)
    ((gate2Sel_reg.in2TrueEn && cellData_next[1]) || (gate2Sel_reg.in2InvEn && !cellData_next[1]))
      |=> gate2Out;
  endproperty
  a_g2_in2: assert property (p_g2_in2) else $error("gate 2 missed input 2 term");

  property p_g2_in1;
    @(posedge clk) disable iff (!arst_n)
    ((gate2Sel_reg.in1TrueEn && cellData_next[0]) || (gate2Sel_reg.in1InvEn && !cellData_next[0]))
      |=> gate2Out;
  endproperty
  a_g2_in1: assert property (p_g2_in1) else $error("gate 2 missed input 1 term");

  property p_g3_in4;
    @(posedge clk) disable iff (!arst_n)
    ((gate3Sel_reg.in4TrueEn && cellData_next[3]) || (gate3Sel_reg.in4InvEn && !cellData_next[3]))
      |=> gate3Out;
  endproperty
  a_g3_in4: assert property (p_g3_in4) else $error("gate 3 missed input 4 term");

  property p_g3_in3;
    @(posedge clk) disable iff (!arst_n)
    ((gate3Sel_reg.in3TrueEn && cellData_next[2]) || (gate3Sel_reg.in3InvEn && !cellData_next[2]))
      |=> gate3Out;
  endproperty
  a_g3_in3: assert property (p_g3_in3) else $error("gate 3 missed input 3 term");

  property p_g3_in2;
    @(posedge clk) disable iff (!arst_n)
    ((gate3Sel_reg.in2TrueEn && cellData_next[1]) || (gate3Sel_reg.in2InvEn && !cellData_next[1]))
      |=> gate3Out;
  endproperty
  a_g3_in2: assert property (p_g3_in2) else $error("gate 3 missed input 2 term");

  property p_g3_in1;
    @(posedge clk) disable iff (!arst_n)
    ((gate3Sel_reg.in1TrueEn && cellData_next[0]) || (gate3Sel_reg.in1InvEn && !cellData_next[0]))
      |=> gate3Out;
  endproperty
  a_g3_in1: assert property (p_g3_in1) else $error("gate 3 missed input 1 term");

  property p_gls_rw;
    @(posedge clk) disable iff (!arst_n)
    (regReq.wrStb && regReq.addr == ADDR_GLS2) ##1
      (regReq.rdStb && regReq.addr == ADDR_GLS2 && !regReq.wrStb)
      |=> rdData == $past(regReq.wrData, 2);
  endproperty
  a_gls_rw: assert property (p_gls_rw) else $error("gate 2 select readback wrong");

  property p_src_sel;
    @(posedge clk) disable iff (!arst_n)
    (regReq.wrStb && regReq.addr == ADDR_SEL1)
      |=> dataSrcSel_reg[1] == $past(regReq.wrData[SEL_FIELD_MSB:SEL_FIELD_LSB])
      ##1 cellDataIn[1] == $past(sourceBus[dataSrcSel_reg[1]]);
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("data input 2 source wrong");

  property p_no_term;
    @(posedge clk) disable iff (!arst_n)
    (gate3Sel_reg == gate_sel_s'(GLS_RESET)) |=> !gate3Out;
  endproperty
  a_no_term: assert property (p_no_term) else $error("gate 3 high with no term");

  property p_g2_none;
    @(posedge clk) disable iff (!arst_n)
    !(   (gate2Sel_reg.in4TrueEn && cellData_next[3])
      || (gate2Sel_reg.in4InvEn && !cellData_next[3])
      || (gate2Sel_reg.in3TrueEn && cellData_next[2])
      || (gate2Sel_reg.in3InvEn && !cellData_next[2])
      || (gate2Sel_reg.in2TrueEn && cellData_next[1])
      || (gate2Sel_reg.in2InvEn && !cellData_next[1])
      || (gate2Sel_reg.in1TrueEn && cellData_next[0])
      || (gate2Sel_reg.in1InvEn && !cellData_next[0]))
      |=> !gate2Out;
  endproperty
  a_g2_none: assert property (p_g2_none) else $error("gate 2 high with no live term");

  property p_g3_none;
    @(posedge clk) disable iff (!arst_n)
    !(   (gate3Sel_reg.in4TrueEn && cellData_next[3])
      || (gate3Sel_reg.in4InvEn && !cellData_next[3])
      || (gate3Sel_reg.in3TrueEn && cellData_next[2])
      || (gate3Sel_reg.in3InvEn && !cellData_next[2])
      || (gate3Sel_reg.in2TrueEn && cellData_next[1])
      || (gate3Sel_reg.in2InvEn && !cellData_next[1])
      || (gate3Sel_reg.in1TrueEn && cellData_next[0])
      || (gate3Sel_reg.in1InvEn && !cellData_next[0]))
      |=> !gate3Out;
  endproperty
  a_g3_none: assert property (p_g3_none) else $error("gate 3 high with no live term");

  property p_gls3_rw;
    @(posedge clk) disable iff (!arst_n)
    (regReq.wrStb && regReq.addr == ADDR_GLS3) ##1
      (regReq.rdStb && regReq.addr == ADDR_GLS3 && !regReq.wrStb)
      |=> rdData == $past(regReq.wrData, 2);
  endproperty
  a_gls3_rw: assert property (p_gls3_rw) else $error("gate 3 select readback wrong");

  property p_gls2_wr;
    @(posedge clk) disable iff (!arst_n)
    (regReq.wrStb && regReq.addr == ADDR_GLS2)
      |=> gate2Sel_reg == gate_sel_s'($past(regReq.wrData));
  endproperty
  a_gls2_wr: assert property (p_gls2_wr) else $error("gate 2 select write lost");

  property p_gls3_wr;
    @(posedge clk) disable iff (!arst_n)
    (regReq.wrStb && regReq.addr == ADDR_GLS3)
      |=> gate3Sel_reg == gate_sel_s'($past(regReq.wrData));
  endproperty
  a_gls3_wr: assert property (p_gls3_wr) else $error("gate 3 select write lost");

  property p_gls2_hold;
    @(posedge clk) disable iff (!arst_n)
    !(regReq.wrStb && regReq.addr == ADDR_GLS2)
      |=> $stable(gate2Sel_reg);
  endproperty
  a_gls2_hold: assert property (p_gls2_hold) else $error("gate 2 select moved unwritten");

  property p_gls3_hold;
    @(posedge clk) disable iff (!arst_n)
    !(regReq.wrStb && regReq.addr == ADDR_GLS3)
      |=> $stable(gate3Sel_reg);
  endproperty
  a_gls3_hold: assert property (p_gls3_hold) else $error("gate 3 select moved unwritten");

  property p_rd_idle;
    @(posedge clk) disable iff (!arst_n)
    !regReq.rdStb
      |=> rdData == RD_IDLE;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data left standing");

  property p_rd_unmapped;
    @(posedge clk) disable iff (!arst_n)
    (regReq.rdStb && regReq.addr > ADDR_GLS3)
      |=> rdData == RD_IDLE;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_sel_rd;
    @(posedge clk) disable iff (!arst_n)
    (regReq.rdStb && regReq.addr < ADDR_GLS2)
      |=> rdData[DATA_W-1:SRC_SEL_W] == '0;
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("source select upper bits set");

  property p_data_track;
    @(posedge clk) disable iff (!arst_n)
    1'b1 |=> cellDataIn == $past({sourceBus[dataSrcSel_reg[3]], sourceBus[dataSrcSel_reg[2]],
                                  sourceBus[dataSrcSel_reg[1]], sourceBus[dataSrcSel_reg[0]]});
  endproperty
  a_data_track: assert property (p_data_track) else $error("data inputs off their sources");

endmodule // clc_gate_select

`default_nettype wire

// ### clc_gate_select_tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module clc_gate_select_tb;
  import clc_gate_pkg::*;

  logic                 clk = 1'b0;
  logic                 arst_n = 1'b0;
  reg_req_s             regReq = '0;
  logic [SRC_COUNT-1:0] sourceBus = '0;
  logic [DATA_W-1:0]    rdData;
  logic [NUM_DATA-1:0]  cellDataIn;
  logic                 gate2Out;
  logic                 gate3Out;
  logic [15:0]          lfsrState = 16'hA4A2;
  logic [DATA_W-1:0]    regM [6];
  logic [NUM_DATA-1:0]  dM;
  logic [DATA_W-1:0]    rdE;
  logic [13:0]          expQ [$];
  logic [13:0]          expV;
  int                   failures = 0;
  int                   num_checks = 0;

  clc_gate_select i_clc_gate_select (
    .clk        (clk),
    .arst_n     (arst_n),
    .regReq     (regReq),
    .sourceBus  (sourceBus),
    .rdData     (rdData),
    .cellDataIn (cellDataIn),
    .gate2Out   (gate2Out),
    .gate3Out   (gate3Out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and pseudo-random source
  always #5 clk = ~clk;

  function automatic logic [15:0] nxt();
    lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
    return lfsrState;
  endfunction

  // OR of enabled true and inverted terms
  function automatic logic gate(input logic [7:0] s, input logic [3:0] d);
    logic g;
    g = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      g = g | (s[2*k+1] & d[k]) | (s[2*k] & ~d[k]);
    end
    return g;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reference copy of the registers; notes what each edge must produce
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 6; i++)
      begin
        regM[i] = '0;
      end
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        dM[k] = sourceBus[regM[k][5:0]];
      end
      rdE = (regReq.rdStb && regReq.addr < 3'h6) ? regM[regReq.addr] : RD_IDLE;
      expQ.push_back({rdE, dM, gate(regM[4], dM), gate(regM[5], dM)});
      if (regReq.wrStb && regReq.addr < 3'h6)
      begin
        regM[regReq.addr] = (regReq.addr < 3'h4) ? {2'b00, regReq.wrData[5:0]} : regReq.wrData;
      end
    end
  end

  // Takes the oldest note once the outputs have settled
  always @(negedge clk)
  begin
    if (expQ.size() > 0)
    begin
      expV = expQ.pop_front();
      `CHK(rdData, expV[13:6])
      `CHK(cellDataIn, expV[5:2])
      `CHK(gate2Out, expV[1])
      `CHK(gate3Out, expV[0])
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bus cycle with fresh random sources
  task automatic cyc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq    <= '{wrStb: w, rdStb: r, addr: a, wrData: d};
    sourceBus <= {nxt(), nxt(), nxt(), nxt()};
  endtask

  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #200000;
    failures++;
    summarize();
  end

  // Main sequence
  initial
  begin
    logic [15:0] r;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    // All enables clear gives zero gates; reads after reset
    for (int a = 0; a < 8; a++)
    begin
      cyc(1'b0, 1'b1, a[2:0], 8'h00);
      cyc(1'b0, 1'b0, 3'h0, 8'h00);
    end
    $display("test idle done");
    // Random back-to-back traffic, unmapped offsets included
    repeat (3000)
    begin
      r = nxt();
      cyc(r[0], ~r[0] & r[1], r[4:2], r[15:8]);
    end
    $display("test random done");
    // Each enable on its own for both gates
    for (int b = 0; b < 8; b++)
    begin
      cyc(1'b1, 1'b0, ADDR_GLS2, 8'h01 << b);
      cyc(1'b1, 1'b0, ADDR_GLS3, 8'h80 >> b);
      cyc(1'b1, 1'b0, ADDR_SEL0 + 3'(b % 4), 8'hC0 | 8'(b * 9));
      repeat (12) cyc(1'b0, 1'b0, 3'h0, 8'h00);
      cyc(1'b0, 1'b1, ADDR_GLS2, 8'h00);
      cyc(1'b0, 1'b1, ADDR_GLS3, 8'h00);
    end
    cyc(1'b0, 1'b0, 3'h0, 8'h00);
    repeat (2) @(posedge clk);
    $display("test single enable done");
    summarize();
  end

endmodule // clc_gate_select_tb

`default_nettype wire
